// *** rtl/bss_boot_select.sv ***
/*
 * Boot-source selection: runs the internal boot program step, latches straps,
 * decodes fuses and straps into a boot source, applies configuration, hands off.
 * Assumes straps are static board levels and fuses are stable after reset.
 */
`timescale 1ns/1ps
// Summary of operation
// RULE1 - After power-on reset release, run internal boot program before touching external sources.
// RULE2 - Boot source is chosen from fuse contents combined with four strap bits.
// RULE3 - Strap 0000 takes the boot source wholly from the fuses.
// RULE4 - Strap 0001 enters serial download over USB into internal RAM.
// RULE5 - Strap 0010 boots eMMC on port A; 0011 boots SD on port B.
// RULE6 - Strap 0110 boots serial NOR on quad SPI with three-byte addresses.
// RULE7 - Strap 0111 boots HyperBus-type flash on quad SPI.
// RULE8 - NAND straps 010x are unsupported and flagged as an error.
// RULE9 - Device configuration data is applied before handing control to the image.
// RULE10 - Board must drive every strap; an undriven strap reads zero.
// RULE11 - Strap value is sampled once at reset release and then held; the code samples it at the end of the ROM step.
module bss_boot_select
    import bss_pkg::*;
#(
    parameter int ROM_CYC = BSS_ROM_CYC,
    parameter int CFG_CYC = BSS_CFG_CYC
)
(
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Board straps and fuses.
    input wire logic [3:0] i_boot_strap,
    input wire logic [3:0] i_fuse_boot_select,
    // Status outputs.
    output logic o_rom_active,
    output logic o_src_valid,
    output logic [2:0] o_boot_src,
    output logic o_cfg_apply,
    output logic o_handoff,
    output logic o_error
);
    typedef struct packed
    {
        bss_st_e st;
        logic [BSS_CNT_W-1:0] cnt;
        logic [3:0] strap;
        logic strap_taken;
        bss_stat_s stat;
    } bss_state_s;

    bss_state_s st_ff;
    bss_state_s nxt_st;
    logic [3:0] strap_lvl;

    // Straps arrive from board pins, so each bit is filtered.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sync
            bss_sync u_sync
            (
                .i_ref_clk(i_ref_clk),
                .i_rst_b(i_rst_b),
                .i_pin(i_boot_strap[gi]),
                .o_level(strap_lvl[gi])
            );
        end
    endgenerate

    // Map a four-bit boot code onto a source; fuses reuse the strap encoding.
    function automatic bss_src_e bss_decode(input logic [3:0] code);
        bss_src_e res;
        res = BSS_SRC_INVALID;
        case (code)
            BSS_STRAP_SERIAL: res = BSS_SRC_SERIAL; // [RULE4]
            BSS_STRAP_EMMC: res = BSS_SRC_EMMC; // [RULE5]
            BSS_STRAP_SD: res = BSS_SRC_SD; // [RULE5]
            BSS_STRAP_QSPI_NOR: res = BSS_SRC_QSPI_NOR; // [RULE6]
            BSS_STRAP_QSPI_HYPER: res = BSS_SRC_QSPI_HYPER; // [RULE7]
            default: res = BSS_SRC_INVALID; // [RULE8]
        endcase
        return res;
    endfunction : bss_decode

    // Sequencer; the synchroniser needs a few cycles, covered by the ROM step.
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.stat.cfg_apply = 1'b0;
        case (st_ff.st)
            BSS_ST_RESET:
            begin
                nxt_st.st = BSS_ST_ROM;
                nxt_st.cnt = '0;
                nxt_st.stat.rom_active = 1'b1; // [RULE1]
            end
            BSS_ST_ROM:
            begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
                if (st_ff.cnt == BSS_CNT_W'(ROM_CYC - 1))
                begin
                    nxt_st.st = BSS_ST_SELECT;
                    nxt_st.strap = strap_lvl; // [RULE11] [RULE10]
                    nxt_st.strap_taken = 1'b1;
                end
            end
            BSS_ST_SELECT:
            begin
                nxt_st.stat.rom_active = 1'b0;
                // Zero straps defer to the fuses, else the straps rule.
                if (st_ff.strap == BSS_STRAP_FUSE)
                begin
                    nxt_st.stat.src = bss_decode(i_fuse_boot_select); // [RULE3] [RULE2]
                end
                else
                begin
                    nxt_st.stat.src = bss_decode(st_ff.strap); // [RULE2]
                end
                nxt_st.cnt = '0;
                nxt_st.st = BSS_ST_CONFIG;
            end
            BSS_ST_CONFIG:
            begin
                if (st_ff.stat.src == BSS_SRC_INVALID)
                begin
                    nxt_st.stat.error = 1'b1; // [RULE8]
                    nxt_st.st = BSS_ST_ERROR;
                end
                else
                begin
                    nxt_st.stat.src_valid = 1'b1;
                    nxt_st.stat.cfg_apply = 1'b1; // [RULE9]
                    nxt_st.cnt = st_ff.cnt + 1'b1;
                    if (st_ff.cnt == BSS_CNT_W'(CFG_CYC - 1))
                    begin
                        nxt_st.stat.cfg_apply = 1'b0;
                        nxt_st.stat.handoff = 1'b1; // [RULE9]
                        nxt_st.st = BSS_ST_HANDOFF;
                    end
                end
            end
            BSS_ST_HANDOFF:
            begin
                nxt_st.st = BSS_ST_HANDOFF;
            end
            BSS_ST_ERROR:
            begin
                nxt_st.st = BSS_ST_ERROR;
            end
            default:
            begin
                nxt_st.st = BSS_ST_RESET;
            end
        endcase
    end

    // Held strap never reloads until the next reset.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            st_ff <= '0;
            st_ff.st <= BSS_ST_RESET;
            st_ff.stat.src <= BSS_SRC_NONE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_rom_active = st_ff.stat.rom_active;
    assign o_src_valid = st_ff.stat.src_valid;
    assign o_boot_src = st_ff.stat.src;
    assign o_cfg_apply = st_ff.stat.cfg_apply;
    assign o_handoff = st_ff.stat.handoff;
    assign o_error = st_ff.stat.error;

    // ROM step precedes any valid source.
    property p_rom_first;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        $rose(o_src_valid) |-> $past(o_rom_active, 3);
    endproperty
    a_rom_first: assert property (p_rom_first) else $error("source valid without rom"); // [RULE1]

    // The boot program step must open on the first edge after reset release.
    property p_rom_start;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        st_ff.st == BSS_ST_RESET |=> o_rom_active;
    endproperty
    a_rom_start: assert property (p_rom_start) else $error("rom step not started"); // [RULE1]

    property p_strap_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        st_ff.strap_taken && $past(st_ff.strap_taken) |-> $stable(st_ff.strap);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed"); // [RULE11]

    property p_fuse_path;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        st_ff.st == BSS_ST_SELECT && st_ff.strap == BSS_STRAP_FUSE
        |=> o_boot_src == bss_decode($past(i_fuse_boot_select));
    endproperty
    a_fuse_path: assert property (p_fuse_path) else $error("fuse path wrong"); // [RULE3]

    property p_strap_path;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        st_ff.st == BSS_ST_SELECT && st_ff.strap != BSS_STRAP_FUSE
        |=> o_boot_src == bss_decode($past(st_ff.strap));
    endproperty
    a_strap_path: assert property (p_strap_path) else $error("strap path wrong"); // [RULE2]

    property p_serial;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        st_ff.st == BSS_ST_SELECT && st_ff.strap == BSS_STRAP_SERIAL
        |=> o_boot_src == BSS_SRC_SERIAL;
    endproperty
    a_serial: assert property (p_serial) else $error("serial not chosen"); // [RULE4]

    property p_emmc;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        st_ff.st == BSS_ST_SELECT && st_ff.strap == BSS_STRAP_EMMC
        |=> o_boot_src == BSS_SRC_EMMC;
    endproperty
    a_emmc: assert property (p_emmc) else $error("emmc not chosen"); // [RULE5]

    property p_sd;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        st_ff.st == BSS_ST_SELECT && st_ff.strap == BSS_STRAP_SD |=> o_boot_src == BSS_SRC_SD;
    endproperty
    a_sd: assert property (p_sd) else $error("sd not chosen"); // [RULE5]

    property p_nor;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        st_ff.st == BSS_ST_SELECT && st_ff.strap == BSS_STRAP_QSPI_NOR
        |=> o_boot_src == BSS_SRC_QSPI_NOR;
    endproperty
    a_nor: assert property (p_nor) else $error("nor not chosen"); // [RULE6]

    property p_hyper;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        st_ff.st == BSS_ST_SELECT && st_ff.strap == BSS_STRAP_QSPI_HYPER
        |=> o_boot_src == BSS_SRC_QSPI_HYPER;
    endproperty
    a_hyper: assert property (p_hyper) else $error("hyper not chosen"); // [RULE7]

    property p_nand_err;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        o_boot_src == BSS_SRC_INVALID && st_ff.st == BSS_ST_CONFIG
        |=> o_error && !o_handoff && !o_src_valid;
    endproperty
    a_nand_err: assert property (p_nand_err) else $error("unsupported not flagged"); // [RULE8]

    // Configuration ends in the cycle that hands off; a gap would start an unconfigured image.
    sequence s_cfg_end;
        o_cfg_apply ##1 !o_cfg_apply;
    endsequence
    property p_cfg_end;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        s_cfg_end |-> o_handoff && o_src_valid;
    endproperty
    a_cfg_end: assert property (p_cfg_end) else $error("no handoff after config"); // [RULE9]

    property p_cfg_before_handoff;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        $rose(o_handoff) |-> $past(o_cfg_apply) && !o_cfg_apply;
    endproperty
    a_cfg_before_handoff: assert property (p_cfg_before_handoff) else $error("no config"); // [RULE9]

    property p_cfg_to_handoff;
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        $rose(o_cfg_apply) |-> ##[1:300] o_handoff;
    endproperty
    a_cfg_to_handoff: assert property (p_cfg_to_handoff) else $error("handoff late"); // [RULE9]
endmodule : bss_boot_select

// *** rtl/bss_pkg.sv ***
/*
 * Shared constants and types for the boot-source selection block.
 * Assumes a single 200 MHz clock domain and a synchronous active-low reset.
 */
package bss_pkg;

    // Strap codes on the four boot-select inputs.
    localparam logic [3:0] BSS_STRAP_FUSE = 4'h0;
    localparam logic [3:0] BSS_STRAP_SERIAL = 4'h1;
    localparam logic [3:0] BSS_STRAP_EMMC = 4'h2;
    localparam logic [3:0] BSS_STRAP_SD = 4'h3;
    localparam logic [3:0] BSS_STRAP_NAND0 = 4'h4;
    localparam logic [3:0] BSS_STRAP_NAND1 = 4'h5;
    localparam logic [3:0] BSS_STRAP_QSPI_NOR = 4'h6;
    localparam logic [3:0] BSS_STRAP_QSPI_HYPER = 4'h7;

    // Timing of the internal boot program steps.
    localparam int BSS_CLK_MHZ = 200;
    localparam int BSS_ROM_TIME_NS = 100;
    localparam int BSS_ROM_CYC = (BSS_ROM_TIME_NS * BSS_CLK_MHZ + 999) / 1000;
    localparam int BSS_CFG_CYC = 4;
    localparam int BSS_CNT_W = 8;

    // Boot source codes driven out.
    typedef enum logic [2:0]
    {
        BSS_SRC_NONE,
        BSS_SRC_SERIAL,
        BSS_SRC_EMMC,
        BSS_SRC_SD,
        BSS_SRC_QSPI_NOR,
        BSS_SRC_QSPI_HYPER,
        BSS_SRC_INVALID
    } bss_src_e;

    typedef enum
    {
        BSS_ST_RESET,
        BSS_ST_ROM,
        BSS_ST_SELECT,
        BSS_ST_CONFIG,
        BSS_ST_HANDOFF,
        BSS_ST_ERROR
    } bss_st_e;

    // Status bundle presented to the boot path.
    typedef struct packed
    {
        logic rom_active;
        logic src_valid;
        bss_src_e src;
        logic cfg_apply;
        logic handoff;
        logic error;
    } bss_stat_s;

endpackage : bss_pkg

// *** rtl/bss_sync.sv ***
/*
 * Three-stage synchroniser with agreement filter for one pin input.
 * Assumes the pin may change at any time relative to i_ref_clk.
 */
`timescale 1ns/1ps
module bss_sync
(
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // Pin and filtered level.
    input wire logic i_pin,
    output logic o_level
);
    typedef struct packed
    {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } bss_sync_s;

    bss_sync_s st_ff;
    bss_sync_s nxt_st;

    // Only the second and third stages are compared; the first may be metastable.
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1 = i_pin;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (st_ff.s2 == st_ff.s3)
        begin
            nxt_st.lvl = st_ff.s3;
        end
    end

    // Resetting to zero matches the weak internal pull-down of a strap.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign o_level = st_ff.lvl;
endmodule : bss_sync

// *** test/bss_board_model.sv ***
/*
 * Carrier-board model: strap resistors on the four boot-select pins and the fuse code.
 * Assumes the bench chooses which straps are fitted and what level each one sets.
 */
`timescale 1ns/1ps
module bss_board_model
(
    // Strap levels, fitted mask and fuse code from the bench.
    input wire logic [3:0] i_strap_val,
    input wire logic [3:0] i_strap_oe,
    input wire logic [3:0] i_fuse_val,
    // Pins seen by the device.
    output logic [3:0] o_strap,
    output logic [3:0] o_fuse
);
    // A strap with no resistor fitted falls to the weak internal pull-down.
    // Modelling the pull as a hard zero hides slow edges, which are irrelevant here.
    assign o_strap = i_strap_val & i_strap_oe;
    assign o_fuse = i_fuse_val;
endmodule : bss_board_model

// *** test/boot_source_select_bench.sv ***
/*
 * Self-checking bench for the boot-source selection block.
 * Assumes the board model drives the straps and the fuses stay static within one boot.
 */
`timescale 1ns/1ps
module boot_source_select_bench;
    import bss_pkg::*;
    // Short counts keep each boot to a few dozen cycles.
    localparam int ROM_T = 8;
    localparam int CFG_T = 3;
    logic i_ref_clk;
    logic i_rst_b;
    logic [3:0] strap_val;
    logic [3:0] strap_oe;
    logic [3:0] fuse_val;
    logic [3:0] strap_pin;
    logic [3:0] fuse_pin;
    logic o_rom_active;
    logic o_src_valid;
    logic [2:0] o_boot_src;
    logic o_cfg_apply;
    logic o_handoff;
    logic o_error;
    int n_fail = 0;
    int tests_run = 0;
    int rom_cnt = 0;
    int cfg_cnt = 0;
    int early = 0;

    bss_board_model u_board (.i_strap_val(strap_val), .i_strap_oe(strap_oe),
        .i_fuse_val(fuse_val), .o_strap(strap_pin), .o_fuse(fuse_pin));
    bss_boot_select #(.ROM_CYC(ROM_T), .CFG_CYC(CFG_T)) dut (.i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b), .i_boot_strap(strap_pin), .i_fuse_boot_select(fuse_pin),
        .o_rom_active(o_rom_active), .o_src_valid(o_src_valid), .o_boot_src(o_boot_src),
        .o_cfg_apply(o_cfg_apply), .o_handoff(o_handoff), .o_error(o_error));

    // Free-running 200 MHz clock.
    initial
    begin
        i_ref_clk = 1'b0;
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    // Counts the ROM and configuration phases and flags any source seen during the ROM step.
    always @(negedge i_ref_clk)
    begin
        if (i_rst_b === 1'b1)
        begin
            if (o_rom_active === 1'b1)
            begin
                rom_cnt++;
                if (o_boot_src !== 3'h0 || o_src_valid !== 1'b0 || o_handoff !== 1'b0)
                    early++;
            end
            if (o_cfg_apply === 1'b1)
                cfg_cnt++;
        end
    end

    task automatic cmp_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_src(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t boot source got %0d expected %0d", $time, got, exp);
        end
    endtask : cmp_src

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done

    // One full boot: reset with the given straps, wait for the outcome, then move the straps.
    task automatic run_boot(input logic [3:0] s, input logic [3:0] oe, input logic [3:0] f);
        int n;
        logic [3:0] code;
        logic [2:0] exp_src;
        logic ok;
        @(negedge i_ref_clk);
        i_rst_b = 1'b0;
        strap_val = s;
        strap_oe = oe;
        fuse_val = f;
        repeat (4) @(negedge i_ref_clk);
        rom_cnt = 0;
        cfg_cnt = 0;
        early = 0;
        i_rst_b = 1'b1;
        code = ((s & oe) != 4'h0) ? (s & oe) : f;
        case (code)
            4'h1: exp_src = BSS_SRC_SERIAL;
            4'h2: exp_src = BSS_SRC_EMMC;
            4'h3: exp_src = BSS_SRC_SD;
            4'h6: exp_src = BSS_SRC_QSPI_NOR;
            4'h7: exp_src = BSS_SRC_QSPI_HYPER;
            default: exp_src = BSS_SRC_INVALID;
        endcase
        ok = (exp_src != BSS_SRC_INVALID);
        n = 0;
        while (o_handoff !== 1'b1 && o_error !== 1'b1 && n < 200)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        if (n >= 200)
        begin
            n_fail++;
            $display("[FAIL] %0t boot never finished", $time);
            test_done();
        end
        else
        begin
            // Straps moved after capture must change nothing.
            strap_val = ~s;
            strap_oe = 4'hf;
            repeat (8) @(negedge i_ref_clk);
            cmp_src(o_boot_src, exp_src);
            cmp_bit(o_src_valid, ok, "source valid");
            cmp_bit(o_handoff, ok, "handoff");
            cmp_bit(o_error, !ok, "error");
            cmp_bit(o_cfg_apply, 1'b0, "config idle");
            cmp_bit(cfg_cnt == (ok ? CFG_T - 1 : 0), 1'b1, "config length");
            cmp_bit(rom_cnt == ROM_T + 1, 1'b1, "rom step length");
            cmp_bit(early == 0, 1'b1, "source during rom step");
        end
    endtask : run_boot

    // Main sequence: every strap code, every fuse code, then random partly fitted straps.
    initial
    begin
        int seed;
        i_rst_b = 1'b0;
        strap_val = 4'h0;
        strap_oe = 4'hf;
        fuse_val = 4'h0;
        seed = $urandom(50974);
        repeat (3) @(negedge i_ref_clk);
        for (int s = 0; s < 16; s++)
            run_boot(s[3:0], 4'hf, 4'($urandom));
        for (int f = 0; f < 16; f++)
            run_boot(4'h0, 4'hf, f[3:0]);
        for (int k = 0; k < 12; k++)
            run_boot(4'($urandom), 4'($urandom), 4'($urandom));
        test_done();
    end
endmodule : boot_source_select_bench
